/* File: src/afifo_params.svh */
// constants for the asynchronous slave fifo write port
// assumes one 200 MHz clock shared by both ends
`ifndef AFIFO_PARAMS_SVH
`define AFIFO_PARAMS_SVH

// ****************************************
// widths and depths
// ****************************************
`define AF_DATA_W        16
`define AF_SEL_W         2
`define AF_NUM_FIFO      4
`define AF_DEPTH         8
`define AF_PTR_W         3
`define AF_CNT_W         4
`define AF_NUM_FLAG      2
`define AF_PARTIAL_LEVEL 4'h6

// ****************************************
// timing, in ns and derived cycles
// ****************************************
`define AF_CLK_PERIOD_NS 5
`define AF_T_AS_NS       7
`define AF_T_WR_LOW_NS   20
`define AF_T_PE_LOW_NS   20
`define AF_T_WR_HIGH_NS  10
`define AF_FLAG_LAT_CYC  3
`define AF_CEIL_CYC(t)   (((t) + `AF_CLK_PERIOD_NS - 1) / `AF_CLK_PERIOD_NS)

`endif

/* File: src/afifo_pkg.sv */
// types shared by both ends of the slave fifo write port
// assumes afifo_params.svh on the include path
`include "afifo_params.svh"
`default_nettype none

package afifo_pkg;

   typedef enum logic [1:0]
   {
      FLAG_EMPTY   = 2'h0,
      FLAG_FULL    = 2'h1,
      FLAG_PARTIAL = 2'h2
   } flag_mode_e;

   typedef enum logic [3:0]
   {
      M_IDLE   = 4'h1,
      M_SETUP  = 4'h2,
      M_STROBE = 4'h4,
      M_HOLD   = 4'h8
   } mst_state_e;

   typedef struct packed
   {
      logic                  last;
      logic [`AF_DATA_W-1:0] data;
   } entry_s;

endpackage

`default_nettype wire

/* File: src/afifo_if.sv */
// pins between external master and the fifo device
// assumes both ends clocked by the same CLK
`include "afifo_params.svh"
`default_nettype none

interface afifo_if;
   logic                    slave_select_n;    // chip select, low active
   logic                    write_strobe_n;    // write strobe, low active
   logic                    packet_commit_n;   // packet commit, low active
   logic [`AF_SEL_W-1:0]    fifo_select_lines; // fifo address
   logic [`AF_DATA_W-1:0]   data;              // write data
   logic [`AF_NUM_FLAG-1:0] flag;              // status flags, high true

   modport dev
   (
      input  slave_select_n,
      input  write_strobe_n,
      input  packet_commit_n,
      input  fifo_select_lines,
      input  data,
      output flag
   );

   modport mst
   (
      output slave_select_n,
      output write_strobe_n,
      output packet_commit_n,
      output fifo_select_lines,
      output data,
      input  flag
   );
endinterface

`default_nettype wire

/* File: src/afifo_dev_end.sv */
// device end: four write fifos filled by strobe edges
// assumes strobe pins are synchronous to CLK
`include "afifo_params.svh"
`default_nettype none

// Operation
// R1: master selects no later than strobe
// R2: strobe release stores word, advances pointer
// R3: flags refreshed after each strobe release
// R4: burst strobes store successive words
// R5: commit with write closes short packet
// R6: master commits with last word strobe
// R7: master holds address during commit
// R8: commit without write means zero-length packet
// R9: flags configurable mode and address source
// R10: master never writes a full fifo
// R11: commit not released before write strobe
// R12: ignore strobes while deselected
// R13: write to full fifo is dropped
module afifo_dev_end
(
   input  wire logic                   CLK,                        // clock
   input  wire logic                   RST,                        // async reset, high
   afifo_if.dev                        BUS,                        // pins to master
   input  wire afifo_pkg::flag_mode_e  FLAG_MODE [`AF_NUM_FLAG],   // condition per flag
   input  wire logic [`AF_NUM_FLAG-1:0] FLAG_FIXED,                // 1: fixed fifo, 0: addressed
   input  wire logic [`AF_SEL_W-1:0]   FLAG_FIX_SEL [`AF_NUM_FLAG], // fixed fifo per flag
   input  wire logic [`AF_SEL_W-1:0]   DRAIN_SEL,                  // fifo to drain
   input  wire logic                   DRAIN_READY,                // drain accepts
   output logic                        DRAIN_VALID,                // drain word valid
   output logic [`AF_DATA_W-1:0]       DRAIN_DATA,                 // drain word
   output logic                        DRAIN_LAST,                 // word ends packet
   output logic                        DRAIN_ZLP,                  // zero-length packet
   output logic [`AF_SEL_W-1:0]        DRAIN_FIFO                  // source fifo
);

   localparam int NF = `AF_NUM_FIFO;
   localparam int PW = `AF_PTR_W;
   localparam int CW = `AF_CNT_W;
   localparam int SW = `AF_SEL_W;

   // ****************************************
   // pin sampling and edge detection
   // ****************************************
   logic                  wr_prev_q;
   logic                  pe_prev_q;
   logic                  wr_seen_q;
   logic [`AF_DATA_W-1:0] data_q;
   logic [`AF_SEL_W-1:0]  addr_q;

   wire sel_on   = ~BUS.slave_select_n;
   wire wr_low   = ~BUS.write_strobe_n;
   wire pe_low   = ~BUS.packet_commit_n;
   wire wr_rise  = ~wr_prev_q & BUS.write_strobe_n;
   wire pe_rise  = ~pe_prev_q & BUS.packet_commit_n;
   wire [`AF_SEL_W-1:0] addr_now = BUS.fifo_select_lines;

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         wr_prev_q <= 1'b1;
         pe_prev_q <= 1'b1;
      end
      else
      begin
         wr_prev_q <= BUS.write_strobe_n;
         pe_prev_q <= BUS.packet_commit_n;
      end
   end

   // word and address caught while strobe is low
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         data_q <= '0;
         addr_q <= '0;
      end
      else if (wr_low && sel_on)
      begin
         data_q <= BUS.data;
         addr_q <= addr_now;
      end
   end

   // a write seen during a commit pulse rules out zero length
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         wr_seen_q <= 1'b0;
      else if (pe_rise)
         wr_seen_q <= 1'b0;
      else if (pe_low && wr_low)
         wr_seen_q <= 1'b1;
   end

   // ****************************************
   // write and commit decode
   // ****************************************
   logic [CW-1:0] count_q  [NF];
   logic [PW-1:0] wr_ptr_q [NF];
   logic [PW-1:0] rd_ptr_q [NF];
   logic [NF-1:0] zlp_q;
   logic [NF-1:0] full;
   logic [NF-1:0] empty;
   afifo_pkg::entry_s mem_q [NF][`AF_DEPTH];

   // R12: deselected strobes do nothing
   // R13: full target drops the word
   wire do_wr   = wr_rise & sel_on & ~full[addr_q];
   // R8: commit alone marks zero-length packet
   wire do_zlp  = pe_rise & sel_on & ~wr_seen_q & ~wr_low;
   // R5: commit still low marks last word
   wire wr_last = ~pe_prev_q | pe_low;

   // ****************************************
   // drain side output stage
   // ****************************************
   logic                  dv_q;
   logic                  dlast_q;
   logic                  dzlp_q;
   logic [`AF_DATA_W-1:0] ddata_q;
   logic [`AF_SEL_W-1:0]  dfifo_q;

   wire can_load = ~dv_q | DRAIN_READY;
   wire do_pop   = can_load & ~empty[DRAIN_SEL];
   wire zlp_out  = can_load & empty[DRAIN_SEL] & zlp_q[DRAIN_SEL];
   wire afifo_pkg::entry_s head = mem_q[DRAIN_SEL][rd_ptr_q[DRAIN_SEL]];

   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         dv_q    <= 1'b0;
         dlast_q <= 1'b0;
         dzlp_q  <= 1'b0;
         ddata_q <= '0;
         dfifo_q <= '0;
      end
      else if (can_load)
      begin
         dv_q    <= do_pop | zlp_out;
         dlast_q <= do_pop & head.last;
         dzlp_q  <= zlp_out & ~do_pop;
         ddata_q <= do_pop ? head.data : '0;
         dfifo_q <= DRAIN_SEL;
      end
   end

   assign DRAIN_VALID = dv_q;
   assign DRAIN_DATA  = ddata_q;
   assign DRAIN_LAST  = dlast_q;
   assign DRAIN_ZLP   = dzlp_q;
   assign DRAIN_FIFO  = dfifo_q;

   // ****************************************
   // per fifo pointers and storage
   // ****************************************
   genvar f;
   generate
      for (f = 0; f < NF; f++)
      begin : g_fifo
         localparam logic [SW-1:0] FID = SW'(f);
         wire push   = do_wr & (addr_q == FID);
         wire pop    = do_pop & (DRAIN_SEL == FID);
         wire zset   = do_zlp & (addr_now == FID);
         wire zclr   = zlp_out & ~do_pop & (DRAIN_SEL == FID);
         wire [CW-1:0] cnt_d = count_q[f] + CW'(push) - CW'(pop);

         assign full[f]  = (count_q[f] == CW'(`AF_DEPTH));
         assign empty[f] = (count_q[f] == '0);

         // R2: store then advance pointer
         // R4: each burst edge advances again
         always_ff @(posedge CLK or posedge RST)
         begin
            if (RST)
            begin
               count_q[f]  <= '0;
               wr_ptr_q[f] <= '0;
               rd_ptr_q[f] <= '0;
            end
            else
            begin
               count_q[f]  <= cnt_d;
               wr_ptr_q[f] <= wr_ptr_q[f] + PW'(push);
               rd_ptr_q[f] <= rd_ptr_q[f] + PW'(pop);
            end
         end

         always_ff @(posedge CLK)
         begin
            if (push)
               mem_q[f][wr_ptr_q[f]] <= '{last: wr_last, data: data_q};
         end

         // zero-length marker, a new commit beats the drain
         always_ff @(posedge CLK or posedge RST)
         begin
            if (RST)
               zlp_q[f] <= 1'b0;
            else if (zset)
               zlp_q[f] <= 1'b1;
            else if (zclr)
               zlp_q[f] <= 1'b0;
         end
      end
   endgenerate

   // ****************************************
   // status flags
   // ****************************************
   logic [`AF_NUM_FLAG-1:0] flag_q;

   genvar g;
   generate
      for (g = 0; g < `AF_NUM_FLAG; g++)
      begin : g_flag
         // R9: mode and address source per flag
         wire [`AF_SEL_W-1:0] src = FLAG_FIXED[g] ? FLAG_FIX_SEL[g] : addr_now;
         wire is_part = (count_q[src] >= `AF_PARTIAL_LEVEL);
         wire cond    = (FLAG_MODE[g] == afifo_pkg::FLAG_EMPTY)   ? empty[src] :
                        (FLAG_MODE[g] == afifo_pkg::FLAG_FULL)    ? full[src]  :
                        (FLAG_MODE[g] == afifo_pkg::FLAG_PARTIAL) ? is_part    : 1'b0;

         // R3: flags track fill after every release
         always_ff @(posedge CLK or posedge RST)
         begin
            if (RST)
               flag_q[g] <= 1'b0;
            else
               flag_q[g] <= cond;
         end
      end
   endgenerate

   assign BUS.flag = flag_q;

endmodule

`default_nettype wire

/* File: src/afifo_mst_end.sv */
// master end: drives chip select, strobes and commit
// assumes flag 0 of the device shows full of addressed fifo
`include "afifo_params.svh"
`default_nettype none

module afifo_mst_end
(
   input  wire logic                  CLK,        // clock
   input  wire logic                  RST,        // async reset, high
   afifo_if.mst                       BUS,        // pins to device
   input  wire logic                  CMD_VALID,  // command offered
   output logic                       CMD_READY,  // command taken
   input  wire logic [`AF_DATA_W-1:0] CMD_DATA,   // word to write
   input  wire logic [`AF_SEL_W-1:0]  CMD_SEL,    // target fifo
   input  wire logic                  CMD_COMMIT, // word ends packet
   input  wire logic                  CMD_ZLP     // zero-length packet only
);

   localparam int AS_CYC   = `AF_CEIL_CYC(`AF_T_AS_NS);
   localparam int LOW_CYC  = `AF_CEIL_CYC(`AF_T_WR_LOW_NS > `AF_T_PE_LOW_NS ? `AF_T_WR_LOW_NS : `AF_T_PE_LOW_NS);
   localparam int HIGH_CYC = `AF_CEIL_CYC(`AF_T_WR_HIGH_NS);
   localparam int SET_CYC  = AS_CYC > `AF_FLAG_LAT_CYC ? AS_CYC : `AF_FLAG_LAT_CYC;
   localparam int HLD_CYC  = HIGH_CYC > `AF_FLAG_LAT_CYC ? HIGH_CYC : `AF_FLAG_LAT_CYC;

   afifo_pkg::mst_state_e state_q;
   logic [3:0]            cnt_q;
   logic                  ready_q;
   logic                  sel_n_q;
   logic                  wr_n_q;
   logic                  pe_n_q;
   logic                  zlp_q;
   logic                  commit_q;
   logic [`AF_SEL_W-1:0]  addr_q;
   logic [`AF_DATA_W-1:0] data_q;

   wire take     = CMD_VALID & ready_q;
   wire set_done = (cnt_q == 4'(SET_CYC - 1));
   wire low_done = (cnt_q == 4'(LOW_CYC - 1));
   wire hld_done = (cnt_q == 4'(HLD_CYC - 1));
   // R10: hold off while addressed fifo full
   wire may_go   = zlp_q | ~BUS.flag[0];

   // ****************************************
   // strobe sequencer
   // ****************************************
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state_q  <= afifo_pkg::M_IDLE;
         cnt_q    <= 4'h0;
         ready_q  <= 1'b1;
         sel_n_q  <= 1'b1;
         wr_n_q   <= 1'b1;
         pe_n_q   <= 1'b1;
         zlp_q    <= 1'b0;
         commit_q <= 1'b0;
         addr_q   <= '0;
         data_q   <= '0;
      end
      else
      begin
         case (state_q)
            afifo_pkg::M_IDLE:
            begin
               cnt_q <= 4'h0;
               if (take)
               begin
                  // R1: select and address before strobe
                  ready_q  <= 1'b0;
                  sel_n_q  <= 1'b0;
                  addr_q   <= CMD_SEL;
                  data_q   <= CMD_DATA;
                  zlp_q    <= CMD_ZLP;
                  commit_q <= CMD_COMMIT;
                  state_q  <= afifo_pkg::M_SETUP;
               end
            end
            afifo_pkg::M_SETUP:
            begin
               if (!set_done)
                  cnt_q <= cnt_q + 4'h1;
               else if (may_go)
               begin
                  // R6: commit rides with last word strobe
                  // R11: commit and write fall together
                  cnt_q   <= 4'h0;
                  wr_n_q  <= zlp_q;
                  pe_n_q  <= ~(zlp_q | commit_q);
                  state_q <= afifo_pkg::M_STROBE;
               end
            end
            afifo_pkg::M_STROBE:
            begin
               cnt_q <= cnt_q + 4'h1;
               if (low_done)
               begin
                  cnt_q   <= 4'h0;
                  wr_n_q  <= 1'b1;
                  pe_n_q  <= pe_n_q | zlp_q;
                  state_q <= afifo_pkg::M_HOLD;
               end
            end
            afifo_pkg::M_HOLD:
            begin
               // R11: commit released after write
               // R7: address held until select drops
               pe_n_q <= 1'b1;
               cnt_q  <= cnt_q + 4'h1;
               if (hld_done)
               begin
                  cnt_q   <= 4'h0;
                  sel_n_q <= 1'b1;
                  ready_q <= 1'b1;
                  state_q <= afifo_pkg::M_IDLE;
               end
            end
            default:
            begin
               state_q <= afifo_pkg::M_IDLE;
               ready_q <= 1'b1;
            end
         endcase
      end
   end

   assign CMD_READY             = ready_q;
   assign BUS.slave_select_n    = sel_n_q;
   assign BUS.write_strobe_n    = wr_n_q;
   assign BUS.packet_commit_n   = pe_n_q;
   assign BUS.fifo_select_lines = addr_q;
   assign BUS.data              = data_q;

endmodule

`default_nettype wire

/* File: tb/afifo_props.sv */
// assertions on the pins between master end and device end
// assumes flag 0 is set to full of the addressed fifo
`include "afifo_params.svh"
`default_nettype none

module afifo_props
(
   input wire logic                    CLK,               // clock
   input wire logic                    RST,               // async reset
   input wire logic                    slave_select_n,    // select
   input wire logic                    write_strobe_n,    // strobe
   input wire logic                    packet_commit_n,   // commit
   input wire logic [`AF_SEL_W-1:0]    fifo_select_lines, // address
   input wire logic [`AF_DATA_W-1:0]   data,              // word
   input wire logic [`AF_NUM_FLAG-1:0] flag               // flags
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   // ****************
   // pin sequences
   // ****************
   sequence wr_low;
      (!write_strobe_n)[*4] ##1 write_strobe_n;
   endsequence

   sequence zlp_low;
      (write_strobe_n && !slave_select_n)[*4] ##1 packet_commit_n;
   endsequence

   sel_first_a: assert property ($fell(write_strobe_n) |-> !slave_select_n)
      else $error("strobe without select");
   strobe_width_a: assert property ($fell(write_strobe_n) |-> wr_low)
      else $error("strobe pulse width");
   data_hold_a: assert property (!$past(write_strobe_n) |-> $stable(data))
      else $error("data moved in strobe");
   commit_join_a: assert property ($fell(packet_commit_n) && !write_strobe_n |-> $fell(write_strobe_n))
      else $error("commit not with strobe");
   commit_rel_a: assert property ($rose(packet_commit_n) |-> write_strobe_n && $past(write_strobe_n))
      else $error("commit released early");
   addr_hold_a: assert property (!packet_commit_n && !$past(packet_commit_n) |-> $stable(fifo_select_lines))
      else $error("address moved in commit");
   zlp_frame_a: assert property ($fell(packet_commit_n) && write_strobe_n |-> zlp_low)
      else $error("zlp frame");
   full_guard_a: assert property ($fell(write_strobe_n) |-> !$past(flag[0]))
      else $error("write into full fifo");
   strobe_sel_a: assert property (!write_strobe_n || !packet_commit_n |-> !slave_select_n)
      else $error("strobe while deselected");
endmodule

`default_nettype wire

/* File: tb/test_async_slave_fifo_write_port.sv */
// bench: master end drives device end; a second device is driven raw
// assumes the design files of src/ are compiled first
`include "afifo_params.svh"
`default_nettype none

module test_async_slave_fifo_write_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic                  CLK = 1'b0;
   logic                  RST = 1'b1;
   afifo_if               bus ();
   afifo_if               bus2 ();
   afifo_pkg::flag_mode_e md [2];
   afifo_pkg::flag_mode_e md2 [2];
   logic [1:0]            fs [2];
   logic [1:0]            fs2 [2];
   logic [1:0]            dsel [2];
   logic [1:0]            drdy = 2'h0;
   wire [1:0]             dv;
   wire [1:0]             dl;
   wire [1:0]             dz;
   wire [15:0]            dd [2];
   wire [1:0]             df [2];
   logic                  cv = 1'b0;
   wire                   cr;
   logic                  cc = 1'b0;
   logic                  cz = 1'b0;
   logic [15:0]           cd = 16'h0;
   logic [1:0]            cs = 2'h0;
   logic [31:0]           seed = 32'h44d2;
   int                    err_count = 0;
   int                    compares = 0;

   always #2.5 CLK = ~CLK;

   afifo_mst_end afifo_mst_end_inst (.CLK(CLK), .RST(RST), .BUS(bus.mst), .CMD_VALID(cv), .CMD_READY(cr),
      .CMD_DATA(cd), .CMD_SEL(cs), .CMD_COMMIT(cc), .CMD_ZLP(cz));
   afifo_dev_end afifo_dev_end_inst (.CLK(CLK), .RST(RST), .BUS(bus.dev), .FLAG_MODE(md), .FLAG_FIXED(2'h2),
      .FLAG_FIX_SEL(fs), .DRAIN_SEL(dsel[0]), .DRAIN_READY(drdy[0]), .DRAIN_VALID(dv[0]), .DRAIN_DATA(dd[0]),
      .DRAIN_LAST(dl[0]), .DRAIN_ZLP(dz[0]), .DRAIN_FIFO(df[0]));
   afifo_dev_end afifo_dev_end_inst_b (.CLK(CLK), .RST(RST), .BUS(bus2.dev), .FLAG_MODE(md2), .FLAG_FIXED(2'h1),
      .FLAG_FIX_SEL(fs2), .DRAIN_SEL(dsel[1]), .DRAIN_READY(drdy[1]), .DRAIN_VALID(dv[1]), .DRAIN_DATA(dd[1]),
      .DRAIN_LAST(dl[1]), .DRAIN_ZLP(dz[1]), .DRAIN_FIFO(df[1]));
   afifo_props afifo_props_inst (.CLK(CLK), .RST(RST), .slave_select_n(bus.slave_select_n),
      .write_strobe_n(bus.write_strobe_n), .packet_commit_n(bus.packet_commit_n),
      .fifo_select_lines(bus.fifo_select_lines), .data(bus.data), .flag(bus.flag));

   // ****************
   // helpers
   // ****************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic int kept(input int n);
      return n > `AF_DEPTH ? `AF_DEPTH : n;
   endfunction

   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic fail(input string m);
      $display("mismatch at %0t: %s", $time, m);
      err_count++;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
      compares++;
      if (g !== e)
         fail(m);
   endtask

   task automatic chkb(input logic g, input logic e, input string m);
      compares++;
      if (g !== e)
         fail(m);
   endtask

   task automatic cmd(input logic [1:0] s, input logic [15:0] d, input logic c, input logic z);
      int i;
      for (i = 0; i < 300 && cr !== 1'b1; i++)
         @(negedge CLK);
      if (cr !== 1'b1)
      begin
         fail("master stuck");
         summarize();
      end
      cs = s;
      cd = d;
      cc = c;
      cz = z;
      cv = 1'b1;
      @(negedge CLK);
      cv = 1'b0;
   endtask

   task automatic drain(input int k, input logic [15:0] e, input logic l, input logic z);
      int i;
      for (i = 0; i < 300 && dv[k] !== 1'b1; i++)
         @(negedge CLK);
      if (dv[k] !== 1'b1)
      begin
         fail("drain timeout");
         summarize();
      end
      chk(dd[k], e, "data");
      chkb(dl[k], l, "last");
      chkb(dz[k], z, "zero length");
      chk(16'(df[k]), 16'(dsel[k]), "source fifo");
      drdy[k] = 1'b1;
      @(negedge CLK);
      drdy[k] = 1'b0;
      // keep ready low one cycle so back to back calls never re-raise it at once
      @(negedge CLK);
   endtask

   task automatic raw(input logic n, input logic [1:0] s, input logic [15:0] d, input logic w, input logic c);
      bus2.slave_select_n = n;
      bus2.fifo_select_lines = s;
      bus2.data = d;
      @(negedge CLK);
      bus2.write_strobe_n = ~w;
      bus2.packet_commit_n = ~c;
      repeat (2) @(negedge CLK);
      bus2.write_strobe_n = 1'b1;
      @(negedge CLK);
      bus2.packet_commit_n = 1'b1;
      repeat (3) @(negedge CLK);
      bus2.slave_select_n = 1'b1;
      bus2.data = ~d;
      // let the deselect be seen before the next call drives select again
      @(negedge CLK);
   endtask

   // ****************
   // main sequence
   // ****************
   initial
   begin
      int         n;
      int         k;
      int         i;
      int         nt [3];
      logic [1:0] f;
      logic       z;
      logic [15:0] w [9];
      nt = '{1, 8, 9};
      md = '{afifo_pkg::FLAG_FULL, afifo_pkg::FLAG_EMPTY};
      md2 = '{afifo_pkg::FLAG_PARTIAL, afifo_pkg::FLAG_EMPTY};
      fs = '{2'h0, 2'h0};
      fs2 = '{2'h1, 2'h0};
      dsel = '{2'h1, 2'h2};
      bus2.slave_select_n = 1'b1;
      bus2.write_strobe_n = 1'b1;
      bus2.packet_commit_n = 1'b1;
      bus2.fifo_select_lines = 2'h0;
      bus2.data = 16'h0;
      repeat (4) @(negedge CLK);
      RST = 1'b0;
      for (k = 0; k < 8; k++)
      begin
         f = 2'(rnd());
         n = k < 3 ? nt[k] : 1 + int'(rnd() % 8);
         // no zlp behind a write stalled on a full fifo, the master would hang
         z = 1'(rnd() % 2) & (n <= `AF_DEPTH);
         fs[1] = f;
         dsel[0] = f + 2'h1;
         for (i = 0; i < n; i++)
         begin
            w[i] = 16'(rnd());
            cmd(f, w[i], i == n - 1, 1'b0);
         end
         if (z)
            cmd(f, 16'h0, 1'b0, 1'b1);
         repeat (12) @(negedge CLK);
         chkb(bus.flag[1], 1'b0, "not empty");
         if (n > `AF_DEPTH)
            chkb(bus.flag[0], 1'b1, "full");
         dsel[0] = f;
         for (i = 0; i < n; i++)
            drain(0, w[i], i == n - 1, 1'b0);
         if (z)
            drain(0, 16'h0, 1'b0, 1'b1);
         repeat (4) @(negedge CLK);
         chkb(dv[0], 1'b0, "extra word");
         chkb(bus.flag[1], 1'b1, "empty");
         $display("packet test %0d done", k);
      end
      for (i = 1; i <= 9; i++)
      begin
         w[i-1] = 16'(rnd());
         raw(1'b0, 2'h1, w[i-1], 1'b1, 1'b0);
         chkb(bus2.flag[0], i >= `AF_PARTIAL_LEVEL, "partial");
         chkb(bus2.flag[1], 1'b0, "addressed empty");
      end
      raw(1'b1, 2'h2, 16'h5a5a, 1'b1, 1'b1);
      chkb(bus2.flag[1], 1'b1, "deselected write");
      raw(1'b0, 2'h3, 16'h0, 1'b0, 1'b1);
      dsel[1] = 2'h1;
      for (i = 0; i < kept(9); i++)
         drain(1, w[i], 1'b0, 1'b0);
      dsel[1] = 2'h2;
      repeat (4) @(negedge CLK);
      chkb(dv[1], 1'b0, "deselected stored");
      dsel[1] = 2'h3;
      drain(1, 16'h0, 1'b0, 1'b1);
      repeat (4) @(negedge CLK);
      chkb(dv[1], 1'b0, "extra word");
      $display("raw device test done");
      summarize();
   end
endmodule

`default_nettype wire
